/* include/tcirq_pkg.sv */
`default_nettype none
package tcirq_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CAPTURE_LOW = 8'h22;
  localparam logic [7:0] IDX_CAPTURE_HIGH = 8'h23;
  localparam logic [7:0] IDX_FLAGS = 8'h2A;
  localparam logic [7:0] IDX_ENABLES = 8'h2B;
  localparam logic [7:0] IDX_SYNC_CTRL = 8'h2C;
  localparam logic [7:0] IDX_FLAG_CLEAR = 8'h2D;

  // Flag and enable bit positions
  localparam int BIT_CAPTURE = 5;
  localparam int BIT_COMPARE_B = 2;
  localparam int BIT_COMPARE_A = 1;
  localparam int BIT_OVERFLOW = 0;
  localparam logic [7:0] FLAG_MASK = 8'h27;

  // Prescaler sync control bit positions
  localparam int BIT_SYNC_HALT = 7;
  localparam int BIT_PRESCALER_RESET = 0;

  // Reset values
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Waveform modes that take the capture value as TOP
  localparam logic [3:0] MODE_PWM_PC_CAP = 4'h8;
  localparam logic [3:0] MODE_PWM_P_CAP = 4'hA;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Whole state of the core
  typedef struct packed {
    logic [15:0] capture;
    logic [7:0] temp;
    logic [7:0] flags;
    logic [7:0] enables;
    logic syncHalt;
    logic prescaler_reset_bit;
    logic pinPrev;
    logic compOut;
    logic compPrev;
    logic pendA;
    logic pendB;
    logic awHave;
    logic [7:0] awIdx;
    logic wHave;
    logic [7:0] wByte;
    logic wLane;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
  } tcirq_state_t;

endpackage : tcirq_pkg
`default_nettype wire

/* verilog/tcirq_core.sv */
// Functional notes
// R1: The 16-bit capture value is split into a high byte (bits 15:8) and a low byte (bits 7:0) register.
// R2: A capture pin event, or optionally a comparator output event, copies the counter into the capture value.
// R3: The capture value can be the counter TOP, and then the capture flag sets when the counter reaches it.
// R4: Both capture bytes read as one through a single 8-bit high-byte latch shared with other 16-bit registers.
// R5: Enables sit at bits 5, 2, 1, 0 and a request needs the enable, the global flag and the event flag.
// R6: Flags sit at bits 5, 2, 1, 0 and the capture flag sets on each capture event.
// R7: The compare B flag sets in the timer cycle after the counter equals compare B.
// R8: The compare A flag sets in the timer cycle after the counter equals compare A.
// R9: A forced compare strobe never sets a compare flag on either channel.
// R10: The overflow flag sets on counter overflow, with the moment chosen by the counter core per mode.
// R11: Executing a flag's interrupt vector clears that flag in hardware.
// R12: Writing one to a flag bit clears it and writing zero leaves it.
// R13: While sync halt mode is one the written prescaler reset bit is kept, holding the prescaler in reset.
// R14: Writing sync halt mode to zero clears the prescaler reset bit so the timer resumes.
// R15: Writing one to the prescaler reset bit resets the prescaler and the bit then clears unless sync halt is set.
// R16: The comparator output is high while the positive input exceeds the negative and may trigger capture.
// R17: A hardware set and a software clear of one flag in the same cycle leave the flag set.
`timescale 1ns/1ns
`default_nettype none

module tcirq_core #(
  parameter int ADDR_WIDTH = 12,
  parameter int COMP_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  // AXI4-Lite slave
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Counter core side
  input wire logic timerTick,
  input wire logic [15:0] counterValue,
  input wire logic [15:0] compareAValue,
  input wire logic [15:0] compareBValue,
  input wire logic [3:0] waveformModeSelect,
  input wire logic overflowEvent,
  input wire logic forceCompareAStrobe,
  input wire logic forceCompareBStrobe,
  // Shared high-byte latch
  input wire logic tempLoad,
  input wire logic [7:0] tempLoadValue,
  output logic [7:0] tempByte,
  // Capture sources
  input wire logic capturePin,
  input wire logic [COMP_WIDTH-1:0] comparatorPositiveInput,
  input wire logic [COMP_WIDTH-1:0] comparatorNegativeInput,
  input wire logic captureFromComparator,
  output logic comparatorOutput,
  // Interrupts
  input wire logic globalIrqEnable,
  input wire logic [3:0] vectorAck,
  output logic [3:0] irqRequest,
  output logic irq,
  output logic prescalerReset
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Read value of one register index
  // Unmapped indexes read as zero
  function automatic logic [7:0] readValue(input logic [7:0] idx, input tcirq_pkg::tcirq_state_t s);
    logic [7:0] v;
    v = 8'h00;
    if (idx == tcirq_pkg::IDX_CAPTURE_LOW)
    begin
      v = s.capture[7:0];
    end
    else if (idx == tcirq_pkg::IDX_CAPTURE_HIGH)
    begin
      v = s.temp;
    end
    else if (idx == tcirq_pkg::IDX_FLAGS)
    begin
      v = s.flags;
    end
    else if (idx == tcirq_pkg::IDX_ENABLES)
    begin
      v = s.enables;
    end
    else if (idx == tcirq_pkg::IDX_SYNC_CTRL)
    begin
      v[tcirq_pkg::BIT_SYNC_HALT] = s.syncHalt;
      v[tcirq_pkg::BIT_PRESCALER_RESET] = s.prescaler_reset_bit;
    end
    return v;
  endfunction : readValue

  // Index is a mapped register
  // The clear register is write-only, so a read of it answers an error
  function automatic logic isMapped(input logic [7:0] idx, input logic forWrite);
    logic m;
    m = 1'b0;
    if (idx == tcirq_pkg::IDX_CAPTURE_LOW || idx == tcirq_pkg::IDX_CAPTURE_HIGH)
    begin
      m = 1'b1;
    end
    else if (idx == tcirq_pkg::IDX_FLAGS || idx == tcirq_pkg::IDX_ENABLES)
    begin
      m = 1'b1;
    end
    else if (idx == tcirq_pkg::IDX_SYNC_CTRL)
    begin
      m = 1'b1;
    end
    else if (idx == tcirq_pkg::IDX_FLAG_CLEAR)
    begin
      m = forWrite;
    end
    return m;
  endfunction : isMapped

  // Word index from a byte address
  // Lane bits 1:0 and bits above 9 play no part in decoding
  function automatic logic [7:0] wordIndex(input logic [ADDR_WIDTH-1:0] addr);
    return addr[9:2];
  endfunction : wordIndex

  ////////////////////////////////////////////////////////////////////////////////
  // State

  // Registered state and its next value
  tcirq_pkg::tcirq_state_t state_reg;
  tcirq_pkg::tcirq_state_t state_next;

  logic captureIsTop;
  logic pinEdge;
  logic compEdge;
  logic captureEvent;
  logic topReached;
  logic doWrite;
  logic [7:0] setMask;
  logic [7:0] clearMask;

  // Capture value serves as TOP in these modes
  // In them the pin no longer captures; the value belongs to software
  // R3: TOP mode decode
  assign captureIsTop = (waveformModeSelect == tcirq_pkg::MODE_PWM_PC_CAP)
    || (waveformModeSelect == tcirq_pkg::MODE_PWM_P_CAP)
    || (waveformModeSelect == tcirq_pkg::MODE_CTC_CAP)
    || (waveformModeSelect == tcirq_pkg::MODE_FAST_CAP);

  // Rising edges on the capture sources
  // The comparator edge is taken from its registered output
  // R16: comparator as trigger
  assign pinEdge = capturePin && !state_reg.pinPrev;
  assign compEdge = captureFromComparator && state_reg.compOut && !state_reg.compPrev;
  // A capture is held off while the capture value acts as TOP
  // R2: capture trigger
  assign captureEvent = (pinEdge || compEdge) && !captureIsTop;
  // Sampled only at a tick, so one flag per pass through TOP
  // R3: TOP reached
  assign topReached = captureIsTop && timerTick && (counterValue == state_reg.capture);

  // Write fires once both halves are held and no answer is waiting
  assign doWrite = state_reg.awHave && state_reg.wHave && !state_reg.bValid;

  // Hardware flag sets
  // Compare flags use the match noted at the previous tick
  always_comb
  begin
    setMask = 8'h00;
    // R6: capture flag set
    setMask[tcirq_pkg::BIT_CAPTURE] = captureEvent || topReached;
    // R8: compare A one tick late
    setMask[tcirq_pkg::BIT_COMPARE_A] = timerTick && state_reg.pendA;
    // R7: compare B one tick late
    setMask[tcirq_pkg::BIT_COMPARE_B] = timerTick && state_reg.pendB;
    // R10: overflow from the core
    setMask[tcirq_pkg::BIT_OVERFLOW] = overflowEvent;
  end

  // Vector and software clears
  // Both the flag register and the write-only clear register take ones
  always_comb
  begin
    clearMask = 8'h00;
    // R11: vector clears
    clearMask[tcirq_pkg::BIT_CAPTURE] = vectorAck[3];
    clearMask[tcirq_pkg::BIT_COMPARE_B] = vectorAck[2];
    clearMask[tcirq_pkg::BIT_COMPARE_A] = vectorAck[1];
    clearMask[tcirq_pkg::BIT_OVERFLOW] = vectorAck[0];
    // R12: write one clears
    if (doWrite && state_reg.wLane)
    begin
      if (state_reg.awIdx == tcirq_pkg::IDX_FLAGS || state_reg.awIdx == tcirq_pkg::IDX_FLAG_CLEAR)
      begin
        clearMask = clearMask | state_reg.wByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    // Later assignments win: latch loads from other registers, then a
    // bus write of the high byte, then a low-byte read refreshing it
    state_next = state_reg;
    state_next.pinPrev = capturePin;
    state_next.compPrev = state_reg.compOut;
    // R16: comparator output
    state_next.compOut = comparatorPositiveInput > comparatorNegativeInput;

    // Compare matches noted on a tick; forced strobes never reach here
    // The strobes stay unread on purpose: a forced match moves the
    // output pin in the counter core but owes no flag
    // R9: force strobes ignored
    if (timerTick)
    begin
      state_next.pendA = counterValue == compareAValue;
      state_next.pendB = counterValue == compareBValue;
    end

    // R2: counter into capture
    if (captureEvent)
    begin
      state_next.capture = counterValue;
    end

    // Other 16-bit registers load the shared latch
    // The latch is shared, so any 16-bit access in between spoils a pair
    if (tempLoad)
    begin
      state_next.temp = tempLoadValue;
    end

    // R14: halt off lets the reset drop
    // R15: self-clearing prescaler reset
    // With halt clear a written one stands for one cycle only, which
    // is the single reset pulse the prescaler needs
    if (!state_reg.syncHalt)
    begin
      state_next.prescaler_reset_bit = 1'b0;
    end

    // Write address and data taken independently
    if (s_axi_awvalid && s_axi_awready)
    begin
      state_next.awHave = 1'b1;
      state_next.awIdx = wordIndex(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      state_next.wHave = 1'b1;
      state_next.wByte = s_axi_wdata[7:0];
      state_next.wLane = s_axi_wstrb[0];
    end

    // Register write once both halves are held
    if (doWrite)
    begin
      state_next.awHave = 1'b0;
      state_next.wHave = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp = isMapped(state_reg.awIdx, 1'b1) ? tcirq_pkg::RESP_OKAY : tcirq_pkg::RESP_SLVERR;
      if (state_reg.wLane)
      begin
        // R4: high byte goes to latch
        if (state_reg.awIdx == tcirq_pkg::IDX_CAPTURE_HIGH)
        begin
          state_next.temp = state_reg.wByte;
        end
        // R1: low write joins both bytes
        else if (state_reg.awIdx == tcirq_pkg::IDX_CAPTURE_LOW)
        begin
          state_next.capture = {state_reg.temp, state_reg.wByte};
        end
        // R5: enable register
        else if (state_reg.awIdx == tcirq_pkg::IDX_ENABLES)
        begin
          state_next.enables = state_reg.wByte & tcirq_pkg::FLAG_MASK;
        end
        else if (state_reg.awIdx == tcirq_pkg::IDX_SYNC_CTRL)
        begin
          state_next.syncHalt = state_reg.wByte[tcirq_pkg::BIT_SYNC_HALT];
          // R13: kept while halted
          // R15: written one resets
          // R14: a zero written clears it
          state_next.prescaler_reset_bit = state_reg.wByte[tcirq_pkg::BIT_PRESCALER_RESET];
        end
      end
    end
    if (state_reg.bValid && s_axi_bready)
    begin
      state_next.bValid = 1'b0;
    end

    // Read; a low-byte read latches the high byte
    if (s_axi_arvalid && s_axi_arready)
    begin
      state_next.rValid = 1'b1;
      state_next.rData = readValue(wordIndex(s_axi_araddr), state_reg);
      state_next.rResp = isMapped(wordIndex(s_axi_araddr), 1'b0) ? tcirq_pkg::RESP_OKAY : tcirq_pkg::RESP_SLVERR;
      // R4: atomic 16-bit read
      if (wordIndex(s_axi_araddr) == tcirq_pkg::IDX_CAPTURE_LOW)
      begin
        state_next.temp = state_reg.capture[15:8];
      end
    end
    else if (state_reg.rValid && s_axi_rready)
    begin
      state_next.rValid = 1'b0;
    end

    // Clears apply first and sets after, so no event is lost
    // R17: set wins over clear
    state_next.flags = ((state_reg.flags & ~clearMask) | setMask) & tcirq_pkg::FLAG_MASK;
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      // Clear everything, then lay the reset values on top
      state_reg <= '0;
      state_reg.capture <= tcirq_pkg::CAPTURE_RESET;
      state_reg.temp <= tcirq_pkg::BYTE_RESET;
      state_reg.flags <= tcirq_pkg::BYTE_RESET;
      state_reg.enables <= tcirq_pkg::BYTE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Handshakes
  // Address and data are refused while a response waits to be taken
  assign s_axi_awready = !state_reg.awHave && !state_reg.bValid;
  assign s_axi_wready = !state_reg.wHave && !state_reg.bValid;
  assign s_axi_arready = !state_reg.rValid;
  assign s_axi_bvalid = state_reg.bValid;
  assign s_axi_bresp = state_reg.bResp;
  assign s_axi_rvalid = state_reg.rValid;
  assign s_axi_rresp = state_reg.rResp;
  assign s_axi_rdata = {24'h000000, state_reg.rData};

  // Latch, comparator and prescaler reset straight from flip-flops
  assign tempByte = state_reg.temp;
  assign comparatorOutput = state_reg.compOut;
  // R15: prescaler held in reset
  assign prescalerReset = state_reg.prescaler_reset_bit;

  // R5: per-source requests
  assign irqRequest = {
    state_reg.flags[tcirq_pkg::BIT_CAPTURE] && state_reg.enables[tcirq_pkg::BIT_CAPTURE],
    state_reg.flags[tcirq_pkg::BIT_COMPARE_B] && state_reg.enables[tcirq_pkg::BIT_COMPARE_B],
    state_reg.flags[tcirq_pkg::BIT_COMPARE_A] && state_reg.enables[tcirq_pkg::BIT_COMPARE_A],
    state_reg.flags[tcirq_pkg::BIT_OVERFLOW] && state_reg.enables[tcirq_pkg::BIT_OVERFLOW]
  } & {4{globalIrqEnable}};
  // One level line for the whole timer
  assign irq = |irqRequest;

endmodule : tcirq_core

`default_nettype wire

/* verification/tcirq_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module tcirq_monitor #(
  parameter int COMP_WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [COMP_WIDTH-1:0] comparatorPositiveInput,
  input wire logic [COMP_WIDTH-1:0] comparatorNegativeInput,
  input wire logic comparatorOutput,
  input wire logic globalIrqEnable,
  input wire logic overflowEvent,
  input wire logic [3:0] vectorAck,
  input wire logic [3:0] irqRequest,
  input wire logic irq,
  input wire logic prescalerReset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Bus steps
  sequence seqReadTaken; s_axi_arvalid && s_axi_arready; endsequence
  sequence seqWriteDone; $rose(s_axi_bvalid); endsequence
  ////////////////////////////////////////////////////////////////
  // Read answers appear on time; read and write answers stand
  AST_READ_ANSWER: assert property (seqReadTaken |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response moved");
  ////////////////////////////////////////////////////////////////
  // Interrupt requests
  AST_IRQ_OR: assert property (irq == (|irqRequest))
    else $error("irq not the OR of requests");
  AST_IRQ_GATE: assert property (!globalIrqEnable |-> irqRequest == 4'h0)
    else $error("request without global enable");
  AST_VEC_CLEAR: assert property (vectorAck[0] && !overflowEvent |=> !irqRequest[0])
    else $error("vector did not clear flag");
  // Comparator one cycle late
  AST_CMP_OUT: assert property ($past(reset_n) |-> comparatorOutput == ($past(comparatorPositiveInput) > $past(comparatorNegativeInput)))
    else $error("comparator output wrong");
  // Prescaler reset moves only with a register write or just after one
  AST_PRESC_RISE: assert property ($rose(prescalerReset) |-> seqWriteDone)
    else $error("prescaler reset rose alone");
  AST_PRESC_FALL: assert property ($fell(prescalerReset) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("prescaler reset fell alone");
endmodule : tcirq_monitor
bind tcirq_core tcirq_monitor #(.COMP_WIDTH(COMP_WIDTH)) mon (.*);
`default_nettype wire

/* verification/timer_capture_irq_prescale_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_capture_irq_prescale_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, timerTick = 1'b0, overflowEvent = 1'b0, tempLoad = 1'b0;
  logic forceCompareAStrobe = 1'b0, forceCompareBStrobe = 1'b0, capturePin = 1'b0, captureFromComparator = 1'b0;
  logic globalIrqEnable = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, comparatorOutput, prescalerReset;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb = 4'h1, waveformModeSelect = 4'h0, vectorAck = 4'h0, irqRequest;
  logic [3:0] tops [4] = '{4'h8, 4'hA, 4'hC, 4'hE};
  logic [7:0] tempLoadValue = 8'h00, comparatorPositiveInput = 8'h00, comparatorNegativeInput = 8'h00, tempByte;
  logic [7:0] idxs [5] = '{8'h22, 8'h23, 8'h2A, 8'h2B, 8'h2C};
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [15:0] counterValue = 16'h0000, compareAValue = 16'h0000, compareBValue = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rnd = 32'h3E8D1DF4;
  int fails = 0, compares = 0, tests = 0, cyc = 0, psrHigh = 0, mark = 0;

  tcirq_core uut (.*);

  // Clock and hang limit
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (++cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  // Prescaler reset high cycles, seen at the falling edge
  always @(negedge clk_sys)
    if (prescalerReset) psrHigh <= psrHigh + 1;
  ////////////////////////////////////////////////////////////////
  // Random source and expected requests
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [3:0] exp_irq(input logic [7:0] f, input logic g);
    return {f[5], f[2], f[1], f[0]} & {4{g}};
  endfunction : exp_irq
  // Compare and report
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic done_test;
    tests++;
    $display("test %0d done", tests);
  endtask : done_test
  ////////////////////////////////////////////////////////////////
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat, input logic [1:0] er = 2'h0);
    logic a, b, t;
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h000000, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      {a, b, t, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge clk_sys);
      if (a) s_axi_awvalid <= 1'b0;
      if (b) s_axi_wvalid <= 1'b0;
    end
    while (!t);
    // Ready comes late so the held response is exercised
    s_axi_bready <= 1'b1;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
    chk(r, er);
  endtask : wr
  // Bus read with check of data and response
  task automatic rc(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
    logic a, t;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      {a, t, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clk_sys);
      if (a) s_axi_arvalid <= 1'b0;
    end
    while (!t);
    // Ready comes late so the held read data is exercised
    s_axi_rready <= 1'b1;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
    chk({r, d}, {er, 24'h000000, e});
  endtask : rc
  task automatic tick;
    @(posedge clk_sys);
    timerTick <= 1'b1;
    @(posedge clk_sys);
    timerTick <= 1'b0;
  endtask : tick
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (idxs[i]) rc(idxs[i], 8'h00);
    rc(8'h30, 8'h00, 2'h2);
    rc(8'h2D, 8'h00, 2'h2);
    wr(8'h30, 8'h00, 2'h2);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      wr(8'h2B, rnd[7:0]);
      rc(8'h2B, rnd[7:0] & 8'h27);
    end
    // A write with its byte lane off changes nothing
    s_axi_wstrb <= 4'h0;
    wr(8'h2B, 8'hFF);
    s_axi_wstrb <= 4'h1;
    rc(8'h2B, rnd[7:0] & 8'h27);
    done_test();
    // Pin capture, shared latch, masking
    wr(8'h2B, 8'h20);
    rnd = lfsr(rnd);
    counterValue <= rnd[15:0];
    capturePin <= 1'b1;
    globalIrqEnable <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(irqRequest, exp_irq(8'h20, 1'b1));
    rc(8'h2A, 8'h20);
    rc(8'h22, rnd[7:0]);
    chk(tempByte, rnd[15:8]);
    rc(8'h23, rnd[15:8]);
    tempLoad <= 1'b1;
    tempLoadValue <= rnd[31:24];
    @(posedge clk_sys);
    tempLoad <= 1'b0;
    rc(8'h23, rnd[31:24]);
    globalIrqEnable <= 1'b0;
    capturePin <= 1'b0;
    @(negedge clk_sys);
    chk(irq, 1'b0);
    wr(8'h2A, 8'h00);
    rc(8'h2A, 8'h20);
    wr(8'h2A, 8'h20);
    rc(8'h2A, 8'h00);
    done_test();
    // Comparator capture, vector clear
    rnd = lfsr(rnd);
    captureFromComparator <= 1'b1;
    counterValue <= rnd[15:0];
    comparatorPositiveInput <= rnd[23:16] | 8'h80;
    comparatorNegativeInput <= rnd[31:24] & 8'h7F;
    repeat (4) @(negedge clk_sys);
    chk(comparatorOutput, 1'b1);
    rc(8'h22, rnd[7:0]);
    rc(8'h2A, 8'h20);
    vectorAck <= 4'h8;
    @(posedge clk_sys);
    vectorAck <= 4'h0;
    captureFromComparator <= 1'b0;
    rc(8'h2A, 8'h00);
    done_test();
    // Forced strobes, then a match one tick late
    compareAValue <= 16'h1234;
    compareBValue <= 16'h1234;
    counterValue <= 16'h1233;
    forceCompareAStrobe <= 1'b1;
    forceCompareBStrobe <= 1'b1;
    tick();
    forceCompareAStrobe <= 1'b0;
    forceCompareBStrobe <= 1'b0;
    tick();
    rc(8'h2A, 8'h00);
    counterValue <= 16'h1234;
    tick();
    counterValue <= 16'h1235;
    rc(8'h2A, 8'h00);
    tick();
    rc(8'h2A, 8'h06);
    wr(8'h2D, 8'h06);
    rc(8'h2A, 8'h00);
    done_test();
    // Overflow, vector clear, set beating clear
    wr(8'h2B, 8'h01);
    overflowEvent <= 1'b1;
    globalIrqEnable <= 1'b1;
    @(posedge clk_sys);
    overflowEvent <= 1'b0;
    @(negedge clk_sys);
    chk(irqRequest, exp_irq(8'h01, 1'b1));
    rc(8'h2A, 8'h01);
    vectorAck <= 4'h1;
    @(posedge clk_sys);
    vectorAck <= 4'h0;
    rc(8'h2A, 8'h00);
    overflowEvent <= 1'b1;
    vectorAck <= 4'h1;
    @(posedge clk_sys);
    overflowEvent <= 1'b0;
    vectorAck <= 4'h0;
    rc(8'h2A, 8'h01);
    done_test();
    // Capture value as TOP in every such mode
    foreach (tops[i])
    begin
      rnd = lfsr(rnd);
      wr(8'h23, rnd[15:8]);
      wr(8'h22, rnd[7:0]);
      rc(8'h22, rnd[7:0]);
      waveformModeSelect <= tops[i];
      counterValue <= rnd[15:0];
      tick();
      rc(8'h2A, 8'h21);
      wr(8'h2A, 8'h20);
    end
    waveformModeSelect <= 4'h0;
    done_test();
    // Prescaler reset and sync halt
    mark = psrHigh;
    wr(8'h2C, 8'h01);
    chk(prescalerReset, 1'b0);
    chk(psrHigh - mark, 1);
    rc(8'h2C, 8'h00);
    wr(8'h2C, 8'h81);
    chk(prescalerReset, 1'b1);
    rc(8'h2C, 8'h81);
    wr(8'h2C, 8'h00);
    chk(prescalerReset, 1'b0);
    rc(8'h2C, 8'h00);
    done_test();
    print_verdict();
  end
endmodule : timer_capture_irq_prescale_tb
`default_nettype wire
